// ==== design/remote_sensor_map.vh ====
// register ids, frame layout and reset values for the sensor readout port
`ifndef REMOTE_SENSOR_MAP_VH
`define REMOTE_SENSOR_MAP_VH

// frame geometry
`define FRM_BITS          6'h20
`define FRM_LAST_BIT      5'h1F
`define FRM_CNT_MAX       6'h3F
`define ID_BITS           6'h08
`define ID_W              8
`define PARITY_ODD        1'b1

// global status word positions in the response frame
`define GSW_FRAME_FAULT   31
`define GSW_UNUSED_HI     30
`define GSW_SENSOR_FAULT  29
`define GSW_UNUSED_MSB    28
`define GSW_UNUSED_LSB    22
`define GSW_INVALID_ADDR  21
`define GSW_UNUSED_W      7
`define RESP_DATA_MSB     20

// register ids, global select bit on top
`define ID_SENSOR_C0_S1   8'h50
`define ID_SENSOR_C1_S1   8'h51
`define ID_SENSOR_C0_S2   8'h54
`define ID_SENSOR_C1_S2   8'h55
`define ID_SENSOR_C0_S3   8'h58
`define ID_SENSOR_C1_S3   8'h59
`define ID_LEVEL_0        8'h5C
`define ID_LEVEL_1        8'h5D
`define ID_LEVEL_2        8'h5E
`define ID_LEVEL_3        8'h5F
`define ID_ARMING         8'h6A
`define ID_COMPARE_DONE   8'hFF

// register content width and sensor data register fields
`define REG_W             20
`define SDR_CRC_W         3
`define SDR_BODY_W        17
`define SDR_DATA_W        10
`define SDR_LOGICAL_CHANNEL_ID_W        4
`define SDR_CRC_POLY      3'h3
`define SDR_CRC_SEED      3'h7
`define SDR_DATA_RESET    10'h000
`define SDR_EMPTY_RESET   1'b1

`endif

// ==== design/pin_sync.v ====
// two-stage synchroniser for pins from outside the system clock
`timescale 1ns/100ps
module pin_sync #(
	parameter       WIDTH     = 3,
	parameter [2:0] RESET_VAL = 3'h0
) (
	input  wire             clk_in,
	input  wire             rst_b_in,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] stage1;

	// first stage feeds only the second stage
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			stage1   <= RESET_VAL[WIDTH-1:0];
			sync_out <= RESET_VAL[WIDTH-1:0];
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// ==== design/sensor_data_bank.v ====
// per channel/slot sensor values, empty-buffer flags and registered read-out
`timescale 1ns/100ps
`include "remote_sensor_map.vh"
module sensor_data_bank #(
	parameter CHANNELS = 6,
	parameter DATA_W   = 10
) (
	input  wire                       clk_in,
	input  wire                       rst_b_in,
	input  wire [CHANNELS-1:0]        sample_valid_in,
	input  wire [CHANNELS*DATA_W-1:0] sample_data_in,
	input  wire [CHANNELS-1:0]        fault_cond_in,
	input  wire [CHANNELS-1:0]        chan_on_in,
	input  wire                       read_clear_in,
	input  wire [2:0]                 rd_index_in,
	output reg  [`REG_W-1:0]          rd_data_out
);

	reg [DATA_W-1:0]          value [0:CHANNELS-1];
	reg [CHANNELS-1:0]        empty;
	reg [2:0]                 sel;
	reg                       fault_bit;
	reg [`SDR_LOGICAL_CHANNEL_ID_W-1:0]     logical_channel_id;
	reg [`SDR_BODY_W-1:0]     body;
	integer                   i;

	// serial 3-bit crc, msb first over the 17 body bits
	function [`SDR_CRC_W-1:0] crc3;
		input [`SDR_BODY_W-1:0] bits;
		integer k;
		reg [`SDR_CRC_W-1:0] c;
		reg fb;
		begin
			c = `SDR_CRC_SEED;
			for (k = `SDR_BODY_W - 1; k >= 0; k = k - 1) begin
				fb = c[2] ^ bits[k];
				c  = {c[1:0], 1'b0} ^ ({`SDR_CRC_W{fb}} & `SDR_CRC_POLY);
			end
			crc3 = c;
		end
	endfunction

	// value and empty flag per channel; a new sample wins over a read clear
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			for (i = 0; i < CHANNELS; i = i + 1) begin
				value[i] <= `SDR_DATA_RESET;
			end
			empty <= {CHANNELS{`SDR_EMPTY_RESET}};
		end else begin
			for (i = 0; i < CHANNELS; i = i + 1) begin
				// empty cleared by data or other fault
				if (fault_cond_in[i] || sample_valid_in[i]) begin
					empty[i] <= 1'b0;
				end else if (read_clear_in && rd_index_in == i[2:0]) begin
					empty[i] <= 1'b1;
				end
				if (!chan_on_in[i]) begin
					value[i] <= `SDR_DATA_RESET;
				end else if (sample_valid_in[i]) begin
					value[i] <= sample_data_in[i*DATA_W +: DATA_W];
				end else if (read_clear_in && rd_index_in == i[2:0]) begin
					value[i] <= `SDR_DATA_RESET;
				end
			end
		end
	end

	// read word assembly; out-of-range index falls back to entry 0
	always @* begin
		sel  = (rd_index_in < CHANNELS) ? rd_index_in : 3'h0;
		fault_bit  = fault_cond_in[sel] | empty[sel];
		// channel in bit 2, slot in bits 1:0
		logical_channel_id = {1'b0, sel[0], sel[2:1]};
		// no-fault layout, value zero when faulted
		body = {1'b0, fault_bit, chan_on_in[sel], logical_channel_id, fault_bit ? `SDR_DATA_RESET : value[sel]};
	end

	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			rd_data_out <= {`REG_W{1'b0}};
		end else begin
			rd_data_out <= {crc3(body), body};
		end
	end

endmodule

// ==== design/remote_sensor_spi_readout.v ====
// read-only register port of the remote sensor serial link
`timescale 1ns/100ps
`include "remote_sensor_map.vh"
module remote_sensor_spi_readout #(
	parameter CHANNELS = 6,
	parameter DATA_W   = 10,
	parameter LEVELS   = 4
) (
	input  wire                       SYS_CLK_IN,
	input  wire                       RST_B_IN,
	input  wire                       WATCHDOG_STATE_RESET_IN,
	input  wire                       SYSTEM_STATE_RESET_IN,
	input  wire                       SCLK_IN,
	input  wire                       CS_B_IN,
	input  wire                       SENSOR_PORT_HOST_OUT_IN,
	output reg                        SENSOR_PORT_DEVICE_OUT_OUT,
	output reg                        SENSOR_PORT_DEVICE_OUT_OE_B_OUT,
	input  wire [CHANNELS-1:0]        SAMPLE_VALID_IN,
	input  wire [CHANNELS*DATA_W-1:0] SAMPLE_DATA_IN,
	input  wire [CHANNELS-1:0]        FAULT_COND_IN,
	input  wire [CHANNELS-1:0]        CHANNEL_ON_IN,
	input  wire [LEVELS*`REG_W-1:0]   CURRENT_LEVEL_IN,
	input  wire [`REG_W-1:0]          ARMING_STATUS_IN,
	input  wire [`REG_W-1:0]          COMPARE_DONE_IN,
	output reg                        COMPARE_DONE_READ_OUT
);

	// synchronised pins and edge history
	wire [2:0]          pins_s;
	wire                sclk_s;
	wire                cs_b_s;
	wire                mosi_s;
	reg                 sclk_prev;
	reg                 cs_b_prev;
	wire                sclk_rise;
	wire                sclk_fall;
	wire                frame_start;
	wire                frame_end;
	wire                active;
	wire                blk_rst_b;

	// receive side
	reg  [31:0]         rx_shift;
	reg  [5:0]          bit_count;
	reg                 parity;
	reg                 decode_s1;
	reg                 decode_s2;
	reg                 decode_s3;
	reg  [`ID_W-1:0]    cur_id;
	wire                frame_good;

	// transmit side
	reg  [31:0]         resp_word;
	reg  [5:0]          tx_idx;
	wire [5:0]          next_tx_idx;
	reg                 frame_fault;
	wire                sensor_summary;

	// register read-out
	wire [`REG_W-1:0]   sensor_word;
	reg  [`REG_W-1:0]   next_reg_data;
	reg                 read_clear;
	wire                id_mapped;
	wire                good_end;

	// any of the three reset kinds returns the block to its reset state, except the pin synchroniser and edge history, which take RST_B_IN only
	assign blk_rst_b = RST_B_IN & ~WATCHDOG_STATE_RESET_IN & ~SYSTEM_STATE_RESET_IN;

	// true for every id that has a register behind it
	function is_mapped;
		input [`ID_W-1:0] id;
		begin
			case (id)
				`ID_SENSOR_C0_S1, `ID_SENSOR_C1_S1, `ID_SENSOR_C0_S2,
				`ID_SENSOR_C1_S2, `ID_SENSOR_C0_S3, `ID_SENSOR_C1_S3,
				`ID_LEVEL_0, `ID_LEVEL_1, `ID_LEVEL_2, `ID_LEVEL_3,
				`ID_ARMING, `ID_COMPARE_DONE: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// true for the six sensor data registers
	function is_sensor;
		input [`ID_W-1:0] id;
		begin
			case (id)
				`ID_SENSOR_C0_S1, `ID_SENSOR_C1_S1, `ID_SENSOR_C0_S2,
				`ID_SENSOR_C1_S2, `ID_SENSOR_C0_S3, `ID_SENSOR_C1_S3: is_sensor = 1'b1;
				default: is_sensor = 1'b0;
			endcase
		end
	endfunction

	// bank index: slot number times two plus channel
	function [2:0] bank_index;
		input [`ID_W-1:0] id;
		begin
			bank_index = {id[3:2], id[0]};
		end
	endfunction

	// clock, select and data pins come from the host's domain
	pin_sync #(
		.WIDTH     (3),
		.RESET_VAL (3'h2)
	) u_pin_sync (
		.clk_in   (SYS_CLK_IN),
		.rst_b_in (RST_B_IN),
		.async_in ({SCLK_IN, CS_B_IN, SENSOR_PORT_HOST_OUT_IN}),
		.sync_out (pins_s)
	);

	assign sclk_s = pins_s[2];
	assign cs_b_s = pins_s[1];
	assign mosi_s = pins_s[0];

	// edge history taken from the second stage only
	// reset values equal the idle pins, so no false edge follows reset
	always @(posedge SYS_CLK_IN) begin
		if (!RST_B_IN) begin
			sclk_prev <= 1'b0;
			cs_b_prev <= 1'b1;
		end else begin
			sclk_prev <= sclk_s;
			cs_b_prev <= cs_b_s;
		end
	end

	assign sclk_rise   = sclk_s & ~sclk_prev;
	assign sclk_fall   = ~sclk_s & sclk_prev;
	assign frame_start = cs_b_prev & ~cs_b_s;
	assign frame_end   = ~cs_b_prev & cs_b_s;
	assign active      = ~cs_b_s;

	// bit count and parity decide whether the frame was well formed
	assign frame_good = (bit_count == `FRM_BITS) && (parity == `PARITY_ODD);

	// side effects wait for select rise, so a cut frame never clears data
	assign good_end = frame_end && frame_good;

	// host bits are taken on rising clock edges, msb first
	always @(posedge SYS_CLK_IN) begin
		if (!blk_rst_b) begin
			rx_shift  <= 32'h0000_0000;
			bit_count <= 6'h00;
			parity    <= 1'b0;
		end else if (frame_start) begin
			bit_count <= 6'h00;
			parity    <= 1'b0;
		end else if (active && sclk_rise) begin
			rx_shift <= {rx_shift[30:0], mosi_s};
			parity   <= parity ^ mosi_s;
			// saturate so a long frame never wraps back to 32
			if (bit_count != `FRM_CNT_MAX) begin
				bit_count <= bit_count + 6'h01;
			end
		end
	end

	// id decode pipeline: latch id, let the bank answer, then load
	// bit 21 leaves on the tenth fall, the third after the id, so three stages are ample
	always @(posedge SYS_CLK_IN) begin
		if (!blk_rst_b) begin
			decode_s1 <= 1'b0;
			decode_s2 <= 1'b0;
			decode_s3 <= 1'b0;
			cur_id    <= {`ID_W{1'b0}};
		end else begin
			decode_s1 <= active && sclk_rise && (bit_count == `ID_BITS - 6'h01);
			decode_s2 <= decode_s1;
			decode_s3 <= decode_s2;
			// global bit and read id together
			if (decode_s1) begin
				cur_id <= rx_shift[`ID_W-1:0];
			end
		end
	end

	sensor_data_bank #(
		.CHANNELS (CHANNELS),
		.DATA_W   (DATA_W)
	) u_sensor_data_bank (
		.clk_in          (SYS_CLK_IN),
		.rst_b_in        (blk_rst_b),
		.sample_valid_in (SAMPLE_VALID_IN),
		.sample_data_in  (SAMPLE_DATA_IN),
		.fault_cond_in   (FAULT_COND_IN),
		.chan_on_in      (CHANNEL_ON_IN),
		.read_clear_in   (read_clear),
		.rd_index_in     (bank_index(cur_id)),
		.rd_data_out     (sensor_word)
	);

	always @* begin
		case (cur_id)
			`ID_LEVEL_0:      next_reg_data = CURRENT_LEVEL_IN[0*`REG_W +: `REG_W];
			`ID_LEVEL_1:      next_reg_data = CURRENT_LEVEL_IN[1*`REG_W +: `REG_W];
			`ID_LEVEL_2:      next_reg_data = CURRENT_LEVEL_IN[2*`REG_W +: `REG_W];
			`ID_LEVEL_3:      next_reg_data = CURRENT_LEVEL_IN[3*`REG_W +: `REG_W];
			`ID_ARMING:       next_reg_data = ARMING_STATUS_IN;
			`ID_COMPARE_DONE: next_reg_data = COMPARE_DONE_IN;
			default:          next_reg_data = is_sensor(cur_id) ? sensor_word : {`REG_W{1'b0}};
		endcase
	end

	assign sensor_summary = |FAULT_COND_IN;

	// one decode shared by the status flag and the data gate
	assign id_mapped = is_mapped(cur_id);

	// response word: status part at frame start, data part after the id
	always @(posedge SYS_CLK_IN) begin
		if (!blk_rst_b) begin
			resp_word <= 32'h0000_0000;
		end else if (frame_start) begin
			// status word on top of the frame
			resp_word[`GSW_FRAME_FAULT]  <= frame_fault;
			// unused status bits held at zero
			resp_word[`GSW_UNUSED_HI]    <= 1'b0;
			resp_word[`GSW_UNUSED_MSB:`GSW_UNUSED_LSB] <= {`GSW_UNUSED_W{1'b0}};
			resp_word[`GSW_SENSOR_FAULT] <= sensor_summary;
			resp_word[`GSW_INVALID_ADDR:0] <= 22'h00_0000;
		end else if (decode_s3) begin
			// unmapped id flags error in this frame
			// invalid address flag with zeroed data
			resp_word[`GSW_INVALID_ADDR] <= ~id_mapped;
			resp_word[`RESP_DATA_MSB]    <= 1'b0;
			// layout fixed inside the bank; fault bit only zeroes the value
			resp_word[`REG_W-1:0] <= id_mapped ? next_reg_data : {`REG_W{1'b0}};
		end
	end

	// frame fault sticky flag, set wins over clear
	always @(posedge SYS_CLK_IN) begin
		if (!blk_rst_b) begin
			frame_fault <= 1'b0;
		end else if (frame_end && !frame_good) begin
			frame_fault <= 1'b1;
		end else if (frame_start) begin
			frame_fault <= 1'b0;
		end
	end

	// read side effects only for well formed frames with a mapped id
	always @(posedge SYS_CLK_IN) begin
		if (!blk_rst_b) begin
			read_clear            <= 1'b0;
			COMPARE_DONE_READ_OUT <= 1'b0;
		end else begin
			read_clear            <= good_end && is_sensor(cur_id);
			COMPARE_DONE_READ_OUT <= good_end && (cur_id == `ID_COMPARE_DONE);
		end
	end

	assign next_tx_idx = tx_idx + 6'h01;

	// device bits change on falling edges so the host samples them stable
	// a cut frame still drops the enable once select rises
	always @(posedge SYS_CLK_IN) begin
		if (!blk_rst_b) begin
			tx_idx                          <= 6'h00;
			SENSOR_PORT_DEVICE_OUT_OUT      <= 1'b0;
			SENSOR_PORT_DEVICE_OUT_OE_B_OUT <= 1'b1;
		end else if (frame_start) begin
			tx_idx                          <= 6'h00;
			SENSOR_PORT_DEVICE_OUT_OUT      <= frame_fault;
			SENSOR_PORT_DEVICE_OUT_OE_B_OUT <= 1'b0;
		end else if (frame_end) begin
			SENSOR_PORT_DEVICE_OUT_OUT      <= 1'b0;
			SENSOR_PORT_DEVICE_OUT_OE_B_OUT <= 1'b1;
		end else if (active && sclk_fall) begin
			tx_idx <= next_tx_idx;
			// past bit 0 the line simply stays low
			if (next_tx_idx < `FRM_BITS) begin
				SENSOR_PORT_DEVICE_OUT_OUT <= resp_word[`FRM_LAST_BIT - next_tx_idx[4:0]];
			end else begin
				SENSOR_PORT_DEVICE_OUT_OUT <= 1'b0;
			end
		end
	end

endmodule

// ==== dv/rs_readout_assertions.sv ====
// concurrent checks on the pins of the sensor readout port
`timescale 1ns/100ps
module rs_readout_checker (
	input wire SYS_CLK_IN,
	input wire RST_B_IN,
	input wire WATCHDOG_STATE_RESET_IN,
	input wire SYSTEM_STATE_RESET_IN,
	input wire SCLK_IN,
	input wire CS_B_IN,
	input wire SENSOR_PORT_DEVICE_OUT_OUT,
	input wire SENSOR_PORT_DEVICE_OUT_OE_B_OUT,
	input wire COMPARE_DONE_READ_OUT
);
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RST_B_IN);

	// pin clock high long enough that no shift can be in flight
	sequence sclk_held;
		SCLK_IN [*3];
	endsequence
	sequence frame_opens;
		$fell(CS_B_IN);
	endsequence

	a_reset_quiet: assert property ($rose(RST_B_IN) |-> SENSOR_PORT_DEVICE_OUT_OE_B_OUT
		&& !SENSOR_PORT_DEVICE_OUT_OUT && !COMPARE_DONE_READ_OUT)
		else $error("port not idle after reset");
	a_watchdog_clear: assert property (WATCHDOG_STATE_RESET_IN |=> !COMPARE_DONE_READ_OUT)
		else $error("read pulse during watchdog reset");
	a_system_clear: assert property (SYSTEM_STATE_RESET_IN && CS_B_IN |=>
		!SENSOR_PORT_DEVICE_OUT_OUT && !COMPARE_DONE_READ_OUT)
		else $error("state not cleared by system reset");
	a_done_single: assert property (COMPARE_DONE_READ_OUT |=> !COMPARE_DONE_READ_OUT)
		else $error("read pulse longer than one cycle");
	a_done_after_frame: assert property (COMPARE_DONE_READ_OUT |-> CS_B_IN
		&& SENSOR_PORT_DEVICE_OUT_OE_B_OUT)
		else $error("read pulse inside a frame");
	a_oe_opens: assert property (frame_opens |-> ##[1:4] !SENSOR_PORT_DEVICE_OUT_OE_B_OUT)
		else $error("output not enabled after frame start");
	a_oe_closes: assert property ($rose(CS_B_IN) |-> ##[1:4] SENSOR_PORT_DEVICE_OUT_OE_B_OUT)
		else $error("output not released after frame end");
	a_idle_zero: assert property (SENSOR_PORT_DEVICE_OUT_OE_B_OUT |-> !SENSOR_PORT_DEVICE_OUT_OUT)
		else $error("data line not low while idle");
	a_bit_stands: assert property (sclk_held ##0 (!SENSOR_PORT_DEVICE_OUT_OE_B_OUT
		&& $past(!SENSOR_PORT_DEVICE_OUT_OE_B_OUT)) |-> $stable(SENSOR_PORT_DEVICE_OUT_OUT))
		else $error("data bit changed while clock high");
endmodule

// ==== dv/rs_host_model.sv ====
// host serial master sending frames to the sensor readout port
`timescale 1ns/100ps
module rs_host_model (
	output reg  sclk_out,
	output reg  cs_b_out,
	output reg  mosi_out,
	input  wire miso_in,
	input  wire oe_b_in
);
	// clock idles low, select idles high
	initial begin
		sclk_out = 1'b0;
		cs_b_out = 1'b1;
		mosi_out = 1'b0;
	end

	// one frame msb first, 320 ns clock; n below 32 makes a short frame
	task xfer(input [31:0] w, input integer n, output [31:0] r);
		integer i;
		begin
			r = 32'h0;
			// the 7 ns offset keeps every pin change off the system clock edge
			#7 cs_b_out = 1'b0;
			#320;
			for (i = 0; i < n; i = i + 1) begin
				mosi_out = w[31-i];
				#160 sclk_out = 1'b1;
				// an undriven line reads unknown so it never passes a compare
				r = {r[30:0], oe_b_in ? 1'bx : miso_in};
				#160 sclk_out = 1'b0;
			end
			#160 cs_b_out = 1'b1;
			// released line flips so a stale level is never mistaken for data
			mosi_out = ~mosi_out;
			#640;
		end
	endtask
endmodule

// ==== dv/remote_sensor_spi_readout_tb.sv ====
// self-checking bench for the sensor readout port
`timescale 1ns/100ps
`include "remote_sensor_map.vh"
module remote_sensor_spi_readout_tb;
	reg         clk;
	reg         rst_b;
	reg         watchdog_state_reset;
	reg         system_state_reset;
	reg  [5:0]  valid;
	reg  [59:0] sdata;
	reg  [5:0]  fcond;
	reg  [5:0]  chon;
	reg  [79:0] lvl;
	reg  [19:0] arm;
	reg  [19:0] ccd;
	reg  [31:0] r;
	wire        sclk, cs_b, mosi, miso, oe_b, done;
	integer     failures, n_tests, n_done, i, k;

	remote_sensor_spi_readout u_dut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b),
		.WATCHDOG_STATE_RESET_IN(watchdog_state_reset), .SYSTEM_STATE_RESET_IN(system_state_reset), .SCLK_IN(sclk),
		.CS_B_IN(cs_b), .SENSOR_PORT_HOST_OUT_IN(mosi), .SENSOR_PORT_DEVICE_OUT_OUT(miso),
		.SENSOR_PORT_DEVICE_OUT_OE_B_OUT(oe_b), .SAMPLE_VALID_IN(valid), .SAMPLE_DATA_IN(sdata),
		.FAULT_COND_IN(fcond), .CHANNEL_ON_IN(chon), .CURRENT_LEVEL_IN(lvl),
		.ARMING_STATUS_IN(arm), .COMPARE_DONE_IN(ccd), .COMPARE_DONE_READ_OUT(done));
	rs_host_model u_host (.sclk_out(sclk), .cs_b_out(cs_b), .mosi_out(mosi), .miso_in(miso),
		.oe_b_in(oe_b));

	// 25 MHz system clock
	always #20 clk = ~clk;
	always @(posedge clk) if (done === 1'b1) n_done <= n_done + 1;

	task check(input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("unexpected at %0t: got %h want %h", $time, seen, exp);
			end
		end
	endtask

	function [2:0] crc(input [16:0] b);
		integer j;
		reg [2:0] c;
		begin
			c = `SDR_CRC_SEED;
			for (j = 16; j >= 0; j = j - 1)
				c = {c[1:0], 1'b0} ^ ((c[2] ^ b[j]) ? `SDR_CRC_POLY : 3'h0);
			crc = c;
		end
	endfunction

	function [31:0] resp(input f31, input f29, input inv, input [3:0] lc, input fault_bit,
		input [9:0] v);
		begin
			resp = {f31, 1'b0, f29, 7'h00, inv, 1'b0, crc({1'b0, fault_bit, 1'b1, lc, v}),
				1'b0, fault_bit, 1'b1, lc, v};
		end
	endfunction

	// odd parity in the lowest bit keeps the frame well formed
	task rd(input [7:0] id);
		begin
			u_host.xfer({id, 23'h0, ~^id}, 32, r);
			repeat (3) @(posedge clk);
		end
	endtask

	task load(input integer e, input [9:0] v);
		begin
			sdata[e*10 +: 10] <= v;
			valid[e] <= 1'b1;
			@(posedge clk);
			valid <= 6'h00;
			@(posedge clk);
		end
	endtask

	task t_sensor;
		begin
			for (i = 0; i < 6; i = i + 1) begin
				load(i, 10'h2A5 ^ i);
				rd(8'h50 + 4 * (i / 2) + i % 2);
				check(r, resp(0, 0, 0, 4 * (i % 2) + i / 2, 0, 10'h2A5 ^ i));
				rd(8'h50 + 4 * (i / 2) + i % 2);
				check(r, resp(0, 0, 0, 4 * (i % 2) + i / 2, 1, 10'h000));
			end
			load(0, 10'h155);
			chon[0] <= 1'b0;
			@(posedge clk);
			chon[0] <= 1'b1;
			rd(8'h50);
			check({22'h0, r[9:0]}, 32'h0);
		end
	endtask

	task t_fault;
		begin
			fcond[2] <= 1'b1;
			load(2, 10'h0C3);
			rd(8'h54);
			check(r, resp(0, 1, 0, 4'h1, 1, 10'h000));
			fcond[2] <= 1'b0;
			load(2, 10'h3C1);
			rd(8'h54);
			check(r, resp(0, 0, 0, 4'h1, 0, 10'h3C1));
		end
	endtask

	task t_other;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				rd(8'h5C + i);
				check(r, {12'h000, lvl[i*20 +: 20]});
			end
			rd(8'h6A);
			check(r, {12'h000, arm});
			k = n_done;
			rd(8'hFF);
			check(r, {12'h000, ccd});
			check(n_done - k, 1);
		end
	endtask

	task t_invalid;
		begin
			k = n_done;
			for (i = 0; i < 5; i = i + 1) begin
				rd(40'h525B60D07F >> (8 * i));
				check(r, 32'h0020_0000);
			end
			check(n_done - k, 0);
		end
	endtask

	// bad frames, then each reset kind must clear the frame fault flag
	// short frames keep odd parity so only the bit count is wrong
	task t_frame_err;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				k = n_done;
				u_host.xfer(i % 2 ? 32'hFF00_0000 : 32'hFF00_0002, 31 + i % 2, r);
				@(posedge clk);
				watchdog_state_reset <= i == 1;
				system_state_reset <= i == 2;
				rst_b <= i != 3;
				repeat (3) @(posedge clk);
				{watchdog_state_reset, system_state_reset, rst_b} <= 3'b001;
				repeat (3) @(posedge clk);
				rd(8'h7F);
				check(r[31:21], i == 0 ? 11'h401 : 11'h001);
				check(n_done - k, 0);
				rd(8'h7F);
				check(r[31:21], 11'h001);
			end
		end
	endtask

	task summarize;
		begin
			$display("checks %0d mismatches %0d", n_tests, failures);
			if (failures == 0 && n_tests > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask

	initial begin
		{clk, rst_b, watchdog_state_reset, system_state_reset, failures, n_tests, n_done} = 0;
		{valid, sdata, fcond, chon} = {72'h0, 6'h3F};
		lvl = 80'hC3D4E_1A2B3_55AA5_0F0F1;
		arm = 20'h2B6C3;
		ccd = 20'hE7119;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_sensor;
		t_fault;
		t_other;
		t_invalid;
		t_frame_err;
		summarize;
	end

	// watchdog on a hung run
	initial begin
		#2000000;
		failures = failures + 1;
		summarize;
	end
endmodule

bind remote_sensor_spi_readout rs_readout_checker u_chk (.SYS_CLK_IN, .RST_B_IN,
	.WATCHDOG_STATE_RESET_IN, .SYSTEM_STATE_RESET_IN, .SCLK_IN, .CS_B_IN,
	.SENSOR_PORT_DEVICE_OUT_OUT, .SENSOR_PORT_DEVICE_OUT_OE_B_OUT, .COMPARE_DONE_READ_OUT);
